// *** verilog/dbs_pkg.sv ***
/*
  dbs_pkg: constants and types shared by the burst-of-four common-I/O DDR SRAM port.
  assumes: K, K# and C, C# come from the controller; C/C# may be tied high.
*/
// Function
// (RULE1) address and commands sampled only on rising true input clock
// (RULE2) write data captured on rising edges of both input clocks
// (RULE3) controller drives complementary input clock 180 degrees from true clock
// (RULE4) read data launched from output registers by the output clock pair
// (RULE5) echo strobes edge-aligned with read data as data-valid indication
// (RULE6) echo strobes toggle continuously, also while data bus floats
// (RULE7) loop bypass input low bypasses loop and clears lock state
// (RULE8) loop bypass input high enables loop, locked after lock cycles
// (RULE9) bypassed loop gives one-cycle read latency; controller stays under 167 MHz
// (RULE10) address ignored in cycles without a loaded access
// (RULE11) output data follows output clocks, input clocks when both tied high
// (RULE12) data bus floats whenever no read is active
// (RULE13) narrow variant uses lower eighteen lines, upper lines unconnected
// (RULE14) wide variant uses all thirty-six lines for reads and writes
// (RULE15) with load low, read-not-write high reads, low writes
// (RULE16) controller drives load low with address and direction of access
// (RULE17) active-low byte write sampled on same edge as its data beat
// (RULE18) fixed four-beat bursts, new access at most every other cycle
package dbs_pkg;
  localparam int   DQ_PINS  = 36;
  localparam int   DATA_W   = 36;
  localparam int   BYTE_W   = 9;
  localparam int   BEATS    = 4;
  localparam int   ADDR_W   = 18;
  localparam int   LOCK_CYC = 2048;
  localparam int   FIFO_D   = 8;
  localparam logic RST_LOW  = 1'b0;
  localparam logic RST_HIGH = 1'b1;
  typedef enum logic [1:0] {
    DBS_RD_IDLE = 2'b00,
    DBS_RD_ONE  = 2'b01,
    DBS_RD_TWO  = 2'b10
  } dbs_rd_e;
endpackage

// *** verilog/dbs_port.sv ***
/*
  dbs_port: burst-of-four common-I/O DDR SRAM port with its storage array,
  plus dbs_fifo, the write buffer between capture and array.
  assumes: K/K# and C/C# are phase-related link clocks; clk_sys is unrelated.
*/
`timescale 1ns/1ps

module dbs_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,       // clock
  input  wire logic         rst_b,     // async reset, active low
  input  wire logic         in_valid,  // write side offers a word
  output logic              in_ready,  // room for a word
  input  wire logic [W-1:0] in_data,   // word in
  output logic              out_valid, // a word is waiting
  input  wire logic         out_ready, // drain side takes the word
  output logic [W-1:0]      out_data   // oldest word
);
  localparam int PW = $clog2(DEPTH);
  logic [W-1:0] mem_q [DEPTH];
  logic [PW:0]  wp_q;
  logic [PW:0]  wp_d;
  logic [PW:0]  rp_q;
  logic [PW:0]  rp_d;
  logic         push;
  logic         pop;
  // depth must be a power of two for the wrap bit to work
  assign in_ready  = (wp_q - rp_q) != (PW+1)'(DEPTH);
  assign out_valid = wp_q != rp_q;
  assign out_data  = mem_q[rp_q[PW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_comb
  begin
    wp_d = wp_q + (PW+1)'(push);
    rp_d = rp_q + (PW+1)'(pop);
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      wp_q <= '0;
      rp_q <= '0;
    end
    else
    begin
      wp_q <= wp_d;
      rp_q <= rp_d;
    end
  end
  always_ff @(posedge clk)
  begin
    if (push)
      mem_q[wp_q[PW-1:0]] <= in_data;
  end
endmodule // dbs_fifo

module dbs_port #(
  parameter int DW       = dbs_pkg::DATA_W,
  parameter int AW       = dbs_pkg::ADDR_W,
  parameter int LOCK_CYC = dbs_pkg::LOCK_CYC
) (
  input  wire logic                        clk_sys,          // core clock
  input  wire logic                        rst_b,            // async reset, active low
  input  wire logic                        k_clk,            // true input clock
  input  wire logic                        k_n_clk,          // complementary input clock
  input  wire logic                        c_clk,            // true output clock
  input  wire logic                        c_n_clk,          // complementary output clock
  input  wire logic                        dll_bypass_n,     // low: loop bypassed
  input  wire logic                        cycle_load_n,     // access load, active low
  input  wire logic                        read_nwrite,      // high read, low write
  input  wire logic [AW-1:0]               addr_in,          // burst address
  input  wire logic [DW/dbs_pkg::BYTE_W-1:0] byte_write_n,   // byte lane write enables
  input  wire logic [dbs_pkg::DQ_PINS-1:0] data_io_i,        // data bus in
  output logic [dbs_pkg::DQ_PINS-1:0]      data_io_o,        // data bus out
  output logic [dbs_pkg::DQ_PINS-1:0]      data_io_oe,       // data bus drive enable
  output logic                             echo_strobe_true, // echo clock
  output logic                             echo_strobe_inv,  // echo clock inverted
  output logic                             dll_locked,       // loop locked
  output logic                             wbuf_overflow     // sticky: write beats lost
);
  localparam int NB = DW / dbs_pkg::BYTE_W;
  localparam int BR = DW + NB;
  localparam int FW = AW + 1 + 2 * BR;
  localparam int PN = dbs_pkg::DQ_PINS;
  localparam int CW = $clog2(LOCK_CYC + 1);

  function automatic logic [DW-1:0] beat(input logic [dbs_pkg::BEATS*DW-1:0] r, input int i);
    beat = r[i*DW +: DW];
  endfunction

  // core clock: reset, loop control
  logic [1:0]    rs_q;
  logic [1:0]    ds_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          lock_q;
  logic          lock_d;
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      rs_q <= {2{dbs_pkg::RST_LOW}};
    else
      rs_q <= {rs_q[0], dbs_pkg::RST_HIGH};
  end
  always_comb
  begin
    cnt_d  = cnt_q;
    lock_d = lock_q;
    if (!ds_q[1])
    begin
      cnt_d  = '0;          // RULE7
      lock_d = 1'b0;        // RULE7
    end
    else if (!lock_q)
    begin
      cnt_d = cnt_q + CW'(1);
      if (cnt_q == CW'(LOCK_CYC - 1))
        lock_d = 1'b1;      // RULE8
    end
  end
  always_ff @(posedge clk_sys or negedge rs_q[1])
  begin
    if (!rs_q[1])
    begin
      ds_q   <= '0;
      cnt_q  <= '0;
      lock_q <= dbs_pkg::RST_LOW;
    end
    else
    begin
      ds_q   <= {ds_q[0], dll_bypass_n};
      cnt_q  <= cnt_d;
      lock_q <= lock_d;
    end
  end
  assign dll_locked = lock_q;

  // link clock domain
  localparam int BEATS_W = dbs_pkg::BEATS * DW;
  logic [1:0]          rk_q;
  logic [1:0]          ls_q;
  logic [1:0]          ts_q;
  logic                rk_b;
  logic                dll_k;
  logic                o_clk;
  logic                o_n_clk;
  logic                rd_cmd;
  logic                wr_cmd;
  dbs_pkg::dbs_rd_e    rd_q;
  dbs_pkg::dbs_rd_e    rd_d;
  logic                lat_q;
  logic                lat_d;
  logic [BEATS_W-1:0]  row_q;
  logic [BEATS_W-1:0]  row_d;
  logic [DW-1:0]       p1_q;
  logic [DW-1:0]       p1_d;
  logic [DW-1:0]       p2_q;
  logic [DW-1:0]       p2_d;
  logic                v1_q;
  logic                v1_d;
  logic                v2_q;
  logic                v2_d;
  logic [2:0]          ws_q;
  logic [AW-1:0]       wa1_q;
  logic [AW-1:0]       wa2_q;
  logic [BR-1:0]       b0_q;
  logic [BR-1:0]       b2_q;
  logic [BR-1:0]       knb_q;
  logic                ovf_q;
  logic                f_in_rdy;
  logic                f_out_v;
  logic                f_pop;
  logic [FW-1:0]       f_word;
  logic [FW-1:0]       f_out;
  logic [BEATS_W-1:0]  wrow;
  logic [BEATS_W-1:0]  mem_q [2**AW];

  assign rk_b    = rk_q[1];
  assign dll_k   = ls_q[1];
  assign o_clk   = ts_q[1] ? k_clk : c_clk;       // RULE11
  assign o_n_clk = ts_q[1] ? k_n_clk : c_n_clk;   // RULE11
  // load low selects, direction from read_nwrite; a second access in the busy cycle is refused
  assign rd_cmd  = !cycle_load_n && read_nwrite && rd_q != dbs_pkg::DBS_RD_ONE && !ws_q[0]; // RULE15 RULE18
  assign wr_cmd  = !cycle_load_n && !read_nwrite && rd_q != dbs_pkg::DBS_RD_ONE && !ws_q[0]; // RULE15 RULE18

  always_ff @(posedge k_clk or negedge rst_b)
  begin
    if (!rst_b)
      rk_q <= {2{dbs_pkg::RST_LOW}};
    else
      rk_q <= {rk_q[0], dbs_pkg::RST_HIGH};
  end

  always_comb
  begin
    rd_d  = dbs_pkg::DBS_RD_IDLE;
    lat_d = lat_q;
    row_d = row_q;
    p1_d  = p1_q;
    p2_d  = p2_q;
    v1_d  = 1'b0;
    v2_d  = 1'b0;
    case (rd_q)
      dbs_pkg::DBS_RD_ONE:
      begin
        rd_d = dbs_pkg::DBS_RD_TWO;
        p1_d = beat(row_q, lat_q ? 0 : 1);
        p2_d = beat(row_q, lat_q ? 1 : 2);
        v1_d = 1'b1;
        v2_d = 1'b1;
      end
      dbs_pkg::DBS_RD_TWO:
      begin
        p1_d = beat(row_q, lat_q ? 2 : 3);
        p2_d = beat(row_q, 3);
        v1_d = 1'b1;
        v2_d = lat_q;
      end
      default:
        rd_d = dbs_pkg::DBS_RD_IDLE;
    endcase
    if (rd_cmd)
    begin
      rd_d  = dbs_pkg::DBS_RD_ONE;
      lat_d = dll_k;
      row_d = mem_q[addr_in];   // RULE1 RULE10
      if (!dll_k)
      begin
        p2_d = beat(mem_q[addr_in], 0);   // RULE9
        v2_d = 1'b1;                      // RULE9
      end
    end
  end

  // beats 0 and 2 on the true clock edge, 1 and 3 from the K# capture
  assign f_word = {wa2_q, ws_q[2], ws_q[2] ? b2_q : b0_q, knb_q}; // RULE2 RULE17
  assign f_pop  = f_out_v && !rd_cmd;

  always_comb
  begin
    wrow = mem_q[f_out[FW-1 -: AW]];
    for (int j = 0; j < 2; j++)
      for (int l = 0; l < NB; l++)
        if (!f_out[(1-j)*BR + l])
          wrow[(2*f_out[2*BR] + j)*DW + l*dbs_pkg::BYTE_W +: dbs_pkg::BYTE_W] =
            f_out[(1-j)*BR + NB + l*dbs_pkg::BYTE_W +: dbs_pkg::BYTE_W]; // RULE17
  end

  always_ff @(posedge k_clk or negedge rk_b)
  begin
    if (!rk_b)
    begin
      ls_q  <= '0;
      ts_q  <= '0;
      rd_q  <= dbs_pkg::DBS_RD_IDLE;
      lat_q <= dbs_pkg::RST_LOW;
      row_q <= '0;
      p1_q  <= '0;
      p2_q  <= '0;
      v1_q  <= dbs_pkg::RST_LOW;
      v2_q  <= dbs_pkg::RST_LOW;
      ws_q  <= '0;
      wa1_q <= '0;
      wa2_q <= '0;
      b0_q  <= '0;
      b2_q  <= '0;
      ovf_q <= dbs_pkg::RST_LOW;
    end
    else
    begin
      ls_q  <= {ls_q[0], lock_q};
      ts_q  <= {ts_q[0], c_clk & c_n_clk};   // RULE11
      rd_q  <= rd_d;
      lat_q <= lat_d;
      row_q <= row_d;
      p1_q  <= p1_d;
      p2_q  <= p2_d;
      v1_q  <= v1_d;
      v2_q  <= v2_d;
      ws_q  <= {ws_q[1:0], wr_cmd};          // RULE18
      wa1_q <= wr_cmd ? addr_in : wa1_q;     // RULE10
      wa2_q <= ws_q[0] ? wa1_q : wa2_q;
      b0_q  <= ws_q[0] ? {data_io_i[DW-1:0], byte_write_n} : b0_q;   // RULE2 RULE14 RULE13
      b2_q  <= ws_q[1] ? {data_io_i[DW-1:0], byte_write_n} : b2_q;   // RULE2
      ovf_q <= ovf_q | ((ws_q[1] | ws_q[2]) & !f_in_rdy);
    end
  end
  assign wbuf_overflow = ovf_q;

  // storage has no reset, like the array it models
  always_ff @(posedge k_clk)
  begin
    if (f_pop)
      mem_q[f_out[FW-1 -: AW]] <= wrow;
  end

  dbs_fifo #(
    .W     (FW),
    .DEPTH (dbs_pkg::FIFO_D)
  ) u_wbuf (
    .clk       (k_clk),
    .rst_b     (rk_b),
    .in_valid  (ws_q[1] | ws_q[2]),
    .in_ready  (f_in_rdy),
    .in_data   (f_word),
    .out_valid (f_out_v),
    .out_ready (!rd_cmd),
    .out_data  (f_out)
  );

  // K# capture relies on it sitting half a period from K
  logic [DW-1:0] p2h_q;
  logic          v2h_q;
  always_ff @(posedge k_n_clk or negedge rk_b)
  begin
    if (!rk_b)
    begin
      knb_q <= '0;
      p2h_q <= '0;
      v2h_q <= dbs_pkg::RST_LOW;
    end
    else
    begin
      knb_q <= {data_io_i[DW-1:0], byte_write_n};   // RULE2 RULE3 RULE17
      p2h_q <= p2_q;
      v2h_q <= v2_q;
    end
  end

  // output registers on the output clock pair
  logic [DW-1:0] neg_q;
  logic [DW-1:0] pos_q;
  logic          nv_q;
  logic          pv_q;
  logic          tn_q;
  logic          tp_q;
  always_ff @(posedge o_n_clk or negedge rk_b)
  begin
    if (!rk_b)
    begin
      neg_q <= '0;
      nv_q  <= dbs_pkg::RST_LOW;
      tn_q  <= dbs_pkg::RST_LOW;
    end
    else
    begin
      neg_q <= p1_q;      // RULE4
      nv_q  <= v1_q;
      tn_q  <= tp_q;      // RULE6
    end
  end
  always_ff @(posedge o_clk or negedge rk_b)
  begin
    if (!rk_b)
    begin
      pos_q <= '0;
      pv_q  <= dbs_pkg::RST_LOW;
      tp_q  <= dbs_pkg::RST_LOW;
    end
    else
    begin
      pos_q <= p2h_q;     // RULE4
      pv_q  <= v2h_q;
      tp_q  <= ~tn_q;     // RULE6
    end
  end

  // double-rate pins need a level mux after the two launch registers
  logic [PN+DW-1:0] dq_ext;
  logic [PN+DW-1:0] oe_ext;
  assign dq_ext           = {{PN{1'b0}}, o_clk ? pos_q : neg_q};
  assign oe_ext           = {{PN{1'b0}}, {DW{o_clk ? pv_q : nv_q}}};   // RULE12
  assign data_io_o        = dq_ext[PN-1:0];     // RULE13 RULE14
  assign data_io_oe       = oe_ext[PN-1:0];     // RULE13 RULE14
  assign echo_strobe_true = tp_q ^ tn_q;        // RULE5
  assign echo_strobe_inv  = ~(tp_q ^ tn_q);     // RULE5

  property p_lock_clear;
    @(posedge clk_sys) disable iff (!rs_q[1]) !ds_q[1] |=> !lock_q && cnt_q == '0;
  endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("lock kept while bypassed"); // RULE7
  property p_lock_time;
    @(posedge clk_sys) disable iff (!rs_q[1]) $rose(lock_q) |-> $past(cnt_q) == CW'(LOCK_CYC - 1);
  endproperty
  a_lock_time: assert property (p_lock_time) else $error("lock at wrong count"); // RULE8
  property p_addr_hold;
    @(posedge k_clk) disable iff (!rk_b) cycle_load_n |=> $stable(wa1_q) && rd_q != dbs_pkg::DBS_RD_ONE;
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address taken while deselected"); // RULE10
  sequence s_wr_beats;
    ws_q[0] ##1 ws_q[1] ##1 ws_q[2];
  endsequence
  property p_wr_burst;
    @(posedge k_clk) disable iff (!rk_b) wr_cmd |=> s_wr_beats;
  endproperty
  a_wr_burst: assert property (p_wr_burst) else $error("write burst not four beats"); // RULE18
  property p_wr_first;
    @(posedge k_clk) disable iff (!rk_b)
      ws_q[0] |=> f_word[2*BR-1:BR] == $past({data_io_i[DW-1:0], byte_write_n});
  endproperty
  a_wr_first: assert property (p_wr_first) else $error("first beat or lane enable lost"); // RULE17
  property p_rd_dll;
    @(posedge k_clk) disable iff (!rk_b) rd_cmd && dll_k |=> !v1_q ##1 (v1_q && v2_q) [*2];
  endproperty
  a_rd_dll: assert property (p_rd_dll) else $error("locked read slots wrong"); // RULE15
  sequence s_rd_short;
    v2_q ##1 v1_q && v2_q ##1 v1_q;
  endsequence
  property p_rd_bypass;
    @(posedge k_clk) disable iff (!rk_b) rd_cmd && !dll_k |=> s_rd_short;
  endproperty
  a_rd_bypass: assert property (p_rd_bypass) else $error("bypass read latency wrong"); // RULE9
  property p_float;
    @(posedge k_clk) disable iff (!rk_b)
      (v1_q || v2_q) |-> $past(rd_cmd) || $past(rd_cmd, 2) || $past(rd_cmd, 3);
  endproperty
  a_float: assert property (p_float) else $error("drive without a read"); // RULE12
  property p_echo;
    @(posedge o_clk) disable iff (!rk_b) !echo_strobe_true ##1 !echo_strobe_true;
  endproperty
  a_echo: assert property (p_echo) else $error("echo strobe not toggling"); // RULE6
  property p_upper;
    @(posedge k_clk) disable iff (!rk_b) DW < PN |-> data_io_oe[PN-1] == 1'b0;
  endproperty
  a_upper: assert property (p_upper) else $error("unused data line driven"); // RULE13
endmodule // dbs_port

// *** tb/dbs_ctrl_model.sv ***
/*
  dbs_ctrl_model: memory controller facing the burst-of-four DDR SRAM port.
  assumes: bench calls write_row/read_row one at a time; no pull on the data lines.
*/
`timescale 1ns/1ps

module dbs_ctrl_model #(
  parameter int AW = 6
) (
  output logic                k_clk,        // true input clock, 80 ns
  output logic                k_n_clk,      // complementary input clock
  output logic                c_clk,        // true output clock
  output logic                c_n_clk,      // complementary output clock
  output logic                cycle_load_n, // access load
  output logic                read_nwrite,  // access direction
  output logic [AW-1:0]       addr_in,      // row address
  output logic [3:0]          byte_write_n, // lane enables
  output logic [35:0]         data_io_i,    // resolved bus seen by the port
  input  wire logic [35:0]    data_io_o,    // port drive value
  input  wire logic [35:0]    data_io_oe,   // port drive enable
  input  wire logic           c_tie         // tie the output clock pair high
);
  logic        drv;
  logic [35:0] last;

  initial
  begin
    k_clk = 1'b0;
    cycle_load_n = 1'b1;
    read_nwrite = 1'b1;
    addr_in = '0;
    byte_write_n = 4'hf;
    drv = 1'b0;
    last = '0;
    forever #40 k_clk = ~k_clk;
  end

  assign k_n_clk = ~k_clk;
  // output clocks lag k to model board skew; both high when tied
  assign #10 c_clk = c_tie | k_clk;
  assign #10 c_n_clk = c_tie | ~k_clk;
  // released lines show the inverse of the last value, never a stale copy
  assign data_io_i = (data_io_oe & data_io_o) | (~data_io_oe & (drv ? last : ~last));

  task automatic write_row(input logic [AW-1:0] a, input logic [143:0] d, input logic [15:0] bw);
    int i;
    @(posedge k_clk);
    #2;
    cycle_load_n = 1'b0;
    read_nwrite = 1'b0;
    addr_in = a;
    drv = 1'b1;
    last = d[35:0];
    byte_write_n = bw[3:0];
    // beat 0 must still stand at the rise after the command
    @(posedge k_clk);
    #2;
    cycle_load_n = 1'b1;
    addr_in = ~a;
    for (i = 1; i < 5; i++)
    begin
      if (i[0]) @(posedge k_clk);
      else @(posedge k_n_clk);
      #2;
      cycle_load_n = 1'b1;
      addr_in = ~a;
      if (i < 4)
      begin
        last = d[i*36 +: 36];
        byte_write_n = bw[i*4 +: 4];
      end
      else
      begin
        drv = 1'b0;
        byte_write_n = 4'hf;
      end
    end
  endtask

  // dbl keeps load low one more cycle: that load must be ignored
  task automatic read_row(input logic [AW-1:0] a, input logic lk, input logic dbl,
                          output logic [143:0] q, output logic idle);
    int i;
    @(posedge k_clk);
    #2;
    cycle_load_n = 1'b0;
    read_nwrite = 1'b1;
    addr_in = a;
    @(posedge k_clk);
    #2;
    cycle_load_n = ~dbl;
    addr_in = ~a;
    fork
      @(posedge k_clk) #2 cycle_load_n = 1'b1;
    join_none
    // sample mid-beat: first beat one (bypass) or one and a half (locked) cycles after the load edge
    #(lk ? 148 : 108);
    for (i = 0; i < 4; i++)
    begin
      q[i*36 +: 36] = (data_io_oe === '1) ? data_io_o : 36'hx;
      #40;
    end
    idle = (data_io_oe === '0);
  endtask
endmodule // dbs_ctrl_model

// *** tb/test_ddr_burst4_cio_sram_port.sv ***
/*
  test_ddr_burst4_cio_sram_port: self-checking bench for dbs_port, its write buffer included.
  assumes: dbs_pkg and the design files compiled first; dbs_ctrl_model drives the link.
*/
`timescale 1ns/1ps

module test_ddr_burst4_cio_sram_port;
  logic         clk_sys, rst_b, dll_bypass_n, c_tie;
  logic         k_clk, k_n_clk, c_clk, c_n_clk, cycle_load_n, read_nwrite;
  logic [5:0]   addr_in;
  logic [3:0]   byte_write_n;
  logic [35:0]  dq_i, dq_o, dq_oe;
  logic         echo_strobe_true, echo_strobe_inv, dll_locked, wbuf_overflow;
  logic [143:0] mem [64];
  logic [143:0] q, d;
  logic [15:0]  bw;
  logic [5:0]   rows [6];
  logic         idle;
  integer       seed = 72872;
  int           failures = 0;
  int           checks = 0;
  int           echo_cnt = 0;
  int           n;

  dbs_port #(.AW(6), .LOCK_CYC(16)) uut (
    .clk_sys(clk_sys), .rst_b(rst_b), .k_clk(k_clk), .k_n_clk(k_n_clk), .c_clk(c_clk),
    .c_n_clk(c_n_clk), .dll_bypass_n(dll_bypass_n), .cycle_load_n(cycle_load_n),
    .read_nwrite(read_nwrite), .addr_in(addr_in), .byte_write_n(byte_write_n),
    .data_io_i(dq_i), .data_io_o(dq_o), .data_io_oe(dq_oe), .echo_strobe_true(echo_strobe_true),
    .echo_strobe_inv(echo_strobe_inv), .dll_locked(dll_locked), .wbuf_overflow(wbuf_overflow));

  dbs_ctrl_model #(.AW(6)) m (
    .k_clk(k_clk), .k_n_clk(k_n_clk), .c_clk(c_clk), .c_n_clk(c_n_clk),
    .cycle_load_n(cycle_load_n), .read_nwrite(read_nwrite), .addr_in(addr_in),
    .byte_write_n(byte_write_n), .data_io_i(dq_i), .data_io_o(dq_o), .data_io_oe(dq_oe),
    .c_tie(c_tie));

  initial
  begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  always @(echo_strobe_true) echo_cnt++;

  function automatic logic [143:0] merge(logic [143:0] o, logic [143:0] w, logic [15:0] en_n);
    for (int b = 0; b < 16; b++)
      if (!en_n[b]) o[b*9 +: 9] = w[b*9 +: 9];
    return o;
  endfunction

  task automatic chk_row(input logic [143:0] e, input logic [143:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask

  task automatic chk_bit(input logic e, input logic g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask

  task automatic end_test(input string s);
    $display("test %s finished", s);
  endtask

  task automatic stop_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  task automatic read_all(input logic lk);
    for (int i = 0; i < 6; i++)
    begin
      m.read_row(rows[i], lk, 1'b0, q, idle);
      chk_row(mem[rows[i]], q);
      chk_bit(1'b1, idle);
    end
  endtask

  initial
  begin
    #200000;
    failures++;
    stop_test;
  end

  initial
  begin
    rst_b = 1'b0;
    dll_bypass_n = 1'b0;
    c_tie = 1'b0;
    repeat (10) @(posedge clk_sys);
    chk_bit(1'b0, |dq_oe);
    chk_bit(1'b0, dll_locked);
    repeat (10) @(posedge clk_sys);
    #2;
    rst_b = 1'b1;
    repeat (4) @(posedge k_clk);
    #20;
    echo_cnt = 0;
    #320;
    chk_row(144'd8, 144'(echo_cnt));
    chk_bit(~echo_strobe_true, echo_strobe_inv);
    end_test("echo");
    rows[0] = 6'h00;
    rows[1] = 6'h3f;
    for (int i = 2; i < 6; i++) rows[i] = 6'($random(seed));
    // full rows first so that every later expectation is defined
    for (int p = 0; p < 2; p++)
      for (int i = 0; i < 6; i++)
      begin
        d = 144'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)});
        bw = p == 0 ? 16'h0000 : (i == 5 ? 16'hffff : 16'($random(seed)));
        mem[rows[i]] = merge(mem[rows[i]], d, bw);
        m.write_row(rows[i], d, bw);
      end
    // no bypass from the write buffer: let it drain before reading back
    repeat (6) @(posedge k_clk);
    read_all(1'b0);
    chk_bit(1'b0, wbuf_overflow);
    m.read_row(rows[1], 1'b0, 1'b1, q, idle);
    chk_row(mem[rows[1]], q);
    chk_bit(1'b1, idle);
    end_test("bypass");
    c_tie = 1'b1;
    repeat (4) @(posedge k_clk);
    read_all(1'b0);
    c_tie = 1'b0;
    end_test("tied");
    @(posedge clk_sys);
    #2;
    dll_bypass_n = 1'b1;
    repeat (12) @(posedge clk_sys);
    chk_bit(1'b0, dll_locked);
    n = 0;
    while (dll_locked !== 1'b1 && n < 40)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk_bit(1'b1, n < 12);
    repeat (4) @(posedge k_clk);
    read_all(1'b1);
    m.read_row(rows[2], 1'b1, 1'b1, q, idle);
    chk_row(mem[rows[2]], q);
    chk_bit(1'b1, idle);
    @(posedge clk_sys);
    #2;
    dll_bypass_n = 1'b0;
    repeat (4) @(posedge clk_sys);
    chk_bit(1'b0, dll_locked);
    end_test("loop");
    // random lane masks through the write buffer, back to back
    for (int i = 0; i < 6; i++)
    begin
      d = 144'({$random(seed), $random(seed), $random(seed), $random(seed), $random(seed)});
      bw = 16'($random(seed));
      mem[rows[i]] = merge(mem[rows[i]], d, bw);
      m.write_row(rows[i], d, bw);
    end
    repeat (6) @(posedge k_clk);
    chk_bit(1'b0, |dq_oe);
    read_all(1'b0);
    chk_bit(1'b0, wbuf_overflow);
    chk_bit(~echo_strobe_true, echo_strobe_inv);
    end_test("buffer");
    stop_test;
  end
endmodule // test_ddr_burst4_cio_sram_port
